// ### logic/term_router_map.vh
// constants for the multifunction terminal router
`ifndef TERM_ROUTER_MAP_VH
`define TERM_ROUTER_MAP_VH

// register offset (register index 23 hex, byte address 8C of the routing word)
`define ROUTE_REG_ADDR 8'h8C
`define ROUTE_RESET 32'h00000000
`define ROUTE_RW_MASK 32'h0FFFF000
// idle values of the read port and of unrouted inputs
`define READ_IDLE 32'h00000000
`define IDLE_LOW 1'h0
`define IDLE_HIGH 1'h1
// field positions
`define SIX_HI 27
`define SIX_LO 24
`define FIVE_HI 23
`define FIVE_LO 20
`define FOUR_HI 19
`define FOUR_LO 16
`define THREE_HI 15
`define THREE_LO 12
// selector codes
`define SEL_DEFAULT 4'h0
`define SEL_ONE 4'h1
`define SEL_TWO 4'h2
`define SEL_DMA_GNT 4'h2
`define SEL_LOCK 4'h2
`define SEL_IRQ3 4'h3
`define SEL_IRQ5 4'h5
`define SEL_ZV_STAT 4'h6
`define SEL_ZV_SEL 4'h7
`define SEL_AUDIO 4'h8
`define SEL_IRQ9 4'h9
`define SEL_IRQ10 4'hA
`define SEL_IRQ11 4'hB
`define SEL_LED5 4'hC
`define SEL_RING 4'hC
`define SEL_LED 4'hD
`define SEL_EVENT 4'hE
`define SEL_IRQ15 4'hF
`define IRQ_W 16

`endif

// ### logic/terminal_function_router.v
// multifunction terminal router for terminals 3 to 6
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "term_router_map.vh"

module terminal_function_router #(
  parameter IRQ_W = `IRQ_W
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // eeprom preload of the routing word
  input wire eeprom_load,
  input wire [31:0] eeprom_data,
  // strap pins choosing serial bus mode
  input wire power_switch_data0,
  input wire power_switch_data1,
  // internal sources to route out
  input wire [IRQ_W-1:0] irq_lines,
  input wire clkrun_out,
  input wire clkrun_oe,
  input wire serial_interrupt_stream,
  input wire serial_irq_oe,
  input wire gp_output_four,
  input wire gp_output_three,
  input wire central_dma_grant,
  input wire zoom_video_status,
  input wire zoom_video_select,
  input wire card_audio_pwm_out,
  input wire socket_activity_led,
  input wire general_event_out,
  input wire ring_indicate_out,
  input wire lock_out,
  input wire lock_oe,
  input wire scl_out,
  input wire scl_oe,
  // terminal pins, three signals each, index 0 is terminal 3
  input wire [3:0] term_in,
  output reg [3:0] term_out,
  output reg [3:0] term_oe,
  // sampled inputs to internal logic
  output reg gp_input_four,
  output reg gp_input_three,
  output reg clkrun_in,
  output reg lock_in,
  output reg serial_irq_in,
  output reg scl_in,
  output wire serial_bus_mode
);

  // ----------------------------------------------------------------
  // routing register
  // ----------------------------------------------------------------
  reg [31:0] route_r;
  wire [3:0] sel6 = route_r[`SIX_HI:`SIX_LO];
  wire [3:0] sel5 = route_r[`FIVE_HI:`FIVE_LO];
  wire [3:0] sel4 = route_r[`FOUR_HI:`FOUR_LO];
  wire [3:0] sel3 = route_r[`THREE_HI:`THREE_LO];
  // only the routing word decodes; every other address is ignored
  wire wr_hit = reg_wr && (reg_addr == `ROUTE_REG_ADDR);
  wire rd_hit = reg_rd && (reg_addr == `ROUTE_REG_ADDR);

  // normally written once at power-up; a preload takes priority over software
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      route_r <= `ROUTE_RESET;
    end else if (eeprom_load) begin
      route_r <= eeprom_data & `ROUTE_RW_MASK;
    end else if (wr_hit) begin
      // reserved bits held zero; low fields belong to another block
      route_r <= reg_wdata & `ROUTE_RW_MASK;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `READ_IDLE;
    end else if (rd_hit) begin
      reg_rdata <= route_r & `ROUTE_RW_MASK;
    end else begin
      reg_rdata <= `READ_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  reg [3:0] term_s1_r;
  reg [3:0] term_s2_r;
  reg [1:0] vpp_s1_r;
  reg [1:0] vpp_s2_r;

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      term_s1_r <= 4'h0;
      term_s2_r <= 4'h0;
      vpp_s1_r <= 2'h0;
      vpp_s2_r <= 2'h0;
    end else begin
      term_s1_r <= term_in;
      term_s2_r <= term_s1_r;
      vpp_s1_r <= {power_switch_data1, power_switch_data0};
      vpp_s2_r <= vpp_s1_r;
    end
  end

  assign serial_bus_mode = &vpp_s2_r;

  // ----------------------------------------------------------------
  // IRQ selection helpers
  // ----------------------------------------------------------------
  // full-range map for terminals six and three, codes 2..15 -> IRQ n
  function irq_full;
    input [3:0] sel;
    input [IRQ_W-1:0] irqs;
    begin
      irq_full = irqs[sel];
    end
  endfunction

  function is_irq_sub;
    input [3:0] sel;
    begin
      is_irq_sub = (sel >= `SEL_IRQ3 && sel <= `SEL_IRQ5) ||
                   (sel >= `SEL_IRQ9 && sel <= `SEL_IRQ11) ||
                   (sel == `SEL_IRQ15);
    end
  endfunction

  // ----------------------------------------------------------------
  // output routing
  // ----------------------------------------------------------------
  always @* begin
    term_out = 4'h0;
    term_oe = 4'h0;
    // terminal three
    case (sel3)
      `SEL_DEFAULT: begin
        term_out[0] = 1'h0;
        term_oe[0] = 1'h0;
      end
      `SEL_ONE: begin
        term_out[0] = serial_interrupt_stream;
        term_oe[0] = serial_irq_oe;
      end
      default: begin
        term_out[0] = irq_full(sel3, irq_lines);
        term_oe[0] = 1'h1;
      end
    endcase
    // terminal four
    if (serial_bus_mode) begin
      term_out[1] = scl_out;
      term_oe[1] = scl_oe;
    end else begin
      case (sel4)
        `SEL_DEFAULT: begin
          term_out[1] = 1'h0;
          term_oe[1] = 1'h0;
        end
        `SEL_ONE: begin
          term_out[1] = gp_output_three;
          term_oe[1] = 1'h1;
        end
        `SEL_LOCK: begin
          term_out[1] = lock_out;
          term_oe[1] = lock_oe;
        end
        `SEL_ZV_STAT: begin
          term_out[1] = zoom_video_status;
          term_oe[1] = 1'h1;
        end
        `SEL_ZV_SEL: begin
          term_out[1] = zoom_video_select;
          term_oe[1] = 1'h1;
        end
        `SEL_AUDIO: begin
          term_out[1] = card_audio_pwm_out;
          term_oe[1] = 1'h1;
        end
        `SEL_RING: begin
          term_out[1] = ring_indicate_out;
          term_oe[1] = 1'h1;
        end
        `SEL_LED: begin
          term_out[1] = socket_activity_led;
          term_oe[1] = 1'h1;
        end
        `SEL_EVENT: begin
          term_out[1] = general_event_out;
          term_oe[1] = 1'h1;
        end
        default: begin
          term_out[1] = irq_lines[sel4];
          term_oe[1] = is_irq_sub(sel4);
        end
      endcase
    end
    // terminal five
    case (sel5)
      `SEL_DEFAULT: begin
        term_out[2] = 1'h0;
        term_oe[2] = 1'h0;
      end
      `SEL_ONE: begin
        term_out[2] = gp_output_four;
        term_oe[2] = 1'h1;
      end
      `SEL_DMA_GNT: begin
        term_out[2] = central_dma_grant;
        term_oe[2] = 1'h1;
      end
      `SEL_ZV_STAT: begin
        term_out[2] = zoom_video_status;
        term_oe[2] = 1'h1;
      end
      `SEL_ZV_SEL: begin
        term_out[2] = zoom_video_select;
        term_oe[2] = 1'h1;
      end
      `SEL_AUDIO: begin
        term_out[2] = card_audio_pwm_out;
        term_oe[2] = 1'h1;
      end
      // activity led, code 13 is the same
      `SEL_LED5, `SEL_LED: begin
        term_out[2] = socket_activity_led;
        term_oe[2] = 1'h1;
      end
      `SEL_EVENT: begin
        term_out[2] = general_event_out;
        term_oe[2] = 1'h1;
      end
      default: begin
        term_out[2] = irq_lines[sel5];
        term_oe[2] = is_irq_sub(sel5);
      end
    endcase
    // terminal six
    case (sel6)
      `SEL_DEFAULT: begin
        term_out[3] = 1'h0;
        term_oe[3] = 1'h0;
      end
      `SEL_ONE: begin
        term_out[3] = clkrun_out;
        term_oe[3] = clkrun_oe;
      end
      default: begin
        term_out[3] = irq_full(sel6, irq_lines);
        term_oe[3] = 1'h1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sampled inputs, inactive when not routed
  // ----------------------------------------------------------------
  // the pin level reaches internal logic only while its selector, or for scl the serial bus mode, picks it
  wire gp4_routed = (sel5 == `SEL_DEFAULT);
  wire gp3_routed = !serial_bus_mode && (sel4 == `SEL_DEFAULT);
  wire clkrun_routed = (sel6 == `SEL_ONE);
  wire lock_routed = !serial_bus_mode && (sel4 == `SEL_LOCK);
  wire serial_irq_routed = (sel3 == `SEL_ONE);

  // inactive when unrouted; clkrun, lock and serial lines idle high
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gp_input_four <= `IDLE_LOW;
      gp_input_three <= `IDLE_LOW;
      clkrun_in <= `IDLE_HIGH;
      lock_in <= `IDLE_HIGH;
      serial_irq_in <= `IDLE_HIGH;
      scl_in <= `IDLE_HIGH;
    end else begin
      gp_input_four <= gp4_routed ? term_s2_r[2] : `IDLE_LOW;
      gp_input_three <= gp3_routed ? term_s2_r[1] : `IDLE_LOW;
      clkrun_in <= clkrun_routed ? term_s2_r[3] : `IDLE_HIGH;
      lock_in <= lock_routed ? term_s2_r[1] : `IDLE_HIGH;
      serial_irq_in <= serial_irq_routed ? term_s2_r[0] : `IDLE_HIGH;
      scl_in <= serial_bus_mode ? term_s2_r[1] : `IDLE_HIGH;
    end
  end

endmodule
`default_nettype wire

// ### dv/router_properties.sv
// assertions on the terminal router ports
`timescale 1ns/1ps
`default_nettype none
module router_properties #(parameter IRQ_W = 16) (
  // clock, reset, register port
  input wire ref_clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire [31:0] reg_rdata,
  input wire eeprom_load,
  // routed signals
  input wire [IRQ_W-1:0] irq_lines,
  input wire central_dma_grant,
  input wire scl_out,
  input wire [3:0] term_out,
  input wire [3:0] term_oe,
  input wire serial_bus_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // a preload wins over a write, so only clean writes predict routing
  wire wa = reg_wr && reg_addr == 8'h8C && !eeprom_load;
  a_reserved_reads_zero: assert property (reg_rdata[31:28] == 4'h0)
    else $error("reserved bits set");
  a_six_idle_hiz: assert property (wa && reg_wdata[27:24] == 4'h0 |=> !term_oe[3])
    else $error("t6 drives");
  a_six_irq_route: assert property (wa && reg_wdata[27:24] > 4'h1
    |=> term_oe[3] && term_out[3] == irq_lines[$past(reg_wdata[27:24])]) else $error("t6 irq");
  a_five_dma_grant: assert property (wa && reg_wdata[23:20] == 4'h2
    |=> term_oe[2] && term_out[2] == central_dma_grant) else $error("t5 grant");
  a_five_gp_input: assert property (wa && reg_wdata[23:20] == 4'h0 |=> !term_oe[2])
    else $error("t5 drives");
  a_three_idle_hiz: assert property (wa && reg_wdata[15:12] == 4'h0 |=> !term_oe[0])
    else $error("t3 drives");
  a_scl_override: assert property (serial_bus_mode && term_oe[1] |-> term_out[1] == scl_out)
    else $error("t4 not scl");
  a_reset_no_drive: assert property (disable iff (1'h0) sys_rst |-> term_oe == 4'h0)
    else $error("drive in reset");
  c_serial_mode: cover property (serial_bus_mode);
  c_six_irq15: cover property (wa && reg_wdata[27:24] == 4'hF);
  c_preload: cover property (eeprom_load);
endmodule
`default_nettype wire

// ### dv/board_model.sv
// board side of the four terminal wires
`timescale 1ns/1ps
`default_nettype none
module board_model (
  // router pins
  input wire logic [3:0] term_out,
  input wire logic [3:0] term_oe,
  // board drivers
  input wire logic [3:0] brd_oe,
  input wire logic [3:0] brd_val,
  output logic [3:0] term_in
);
  // board pull-ups hold a wire that nobody drives
  always_comb
    for (int i = 0; i < 4; i++)
      term_in[i] = term_oe[i] ? term_out[i] : (brd_oe[i] ? brd_val[i] : 1'h1);
endmodule
`default_nettype wire

// ### dv/multifunction_terminal_router_test.sv
// self-checking bench for the terminal router
`timescale 1ns/1ps
`default_nettype none
module multifunction_terminal_router_test;
  logic ref_clk = 1'h0, sys_rst, reg_wr = 1'h0, reg_rd = 1'h0, eeprom_load = 1'h0;
  logic power_switch_data0 = 1'h0, power_switch_data1 = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, eeprom_data = 32'h0;
  logic [32:0] sv = 33'h0;
  logic [3:0] brd_oe = 4'h0, brd_val = 4'h0;
  wire [31:0] reg_rdata;
  wire [3:0] term_in, term_out, term_oe;
  wire [5:0] smp;
  wire serial_bus_mode;
  int err_total = 0, check_count = 0, cyc = 0;

  terminal_function_router #(.IRQ_W(16)) i_terminal_function_router (.ref_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .eeprom_load, .eeprom_data,
    .power_switch_data0, .power_switch_data1, .irq_lines(sv[15:0]), .gp_output_four(sv[16]),
    .gp_output_three(sv[17]), .central_dma_grant(sv[18]), .zoom_video_status(sv[19]),
    .zoom_video_select(sv[20]), .card_audio_pwm_out(sv[21]), .socket_activity_led(sv[22]),
    .general_event_out(sv[23]), .ring_indicate_out(sv[24]), .clkrun_out(sv[25]),
    .clkrun_oe(sv[26]), .serial_interrupt_stream(sv[27]), .serial_irq_oe(sv[28]),
    .lock_out(sv[29]), .lock_oe(sv[30]), .scl_out(sv[31]), .scl_oe(sv[32]), .term_in,
    .term_out, .term_oe, .gp_input_four(smp[0]), .gp_input_three(smp[1]),
    .clkrun_in(smp[2]), .lock_in(smp[3]), .serial_irq_in(smp[4]), .scl_in(smp[5]),
    .serial_bus_mode);
  board_model i_board_model (.term_out, .term_oe, .brd_oe, .brd_val, .term_in);

  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      complete_run;
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask
  // expected {drive, level} of terminal t (0 is terminal 3) for code c
  function automatic logic [1:0] ex(input int t, input logic [3:0] c);
    if (c == 4'h0) return 2'h0;
    if (t == 0 || t == 3) return c == 4'h1 ? (t == 3 ? sv[26:25] : sv[28:27]) : {1'h1, sv[c]};
    case (c)
      4'h1: return {1'h1, sv[t == 2 ? 16 : 17]};
      4'h2: return t == 2 ? {1'h1, sv[18]} : sv[30:29];
      4'h6, 4'h7, 4'h8: return {1'h1, sv[c + 13]};
      4'hC: return {1'h1, sv[t == 2 ? 22 : 24]};
      4'hD, 4'hE: return {1'h1, sv[c + 9]};
      default: return {1'h1, sv[c]};
    endcase
  endfunction
  task automatic t_regs;
    rd(8'h8C, 32'h0);
    wr(8'h8C, 32'hFFFFFFFF);
    rd(8'h8C, 32'h0FFFF000);
    wr(8'h90, 32'h0);
    rd(8'h90, 32'h0);
    rd(8'h8C, 32'h0FFFF000);
    @(posedge ref_clk);
    eeprom_load <= 1'h1;
    eeprom_data <= 32'h12345678;
    @(posedge ref_clk);
    eeprom_load <= 1'h0;
    rd(8'h8C, 32'h02345000);
    $display("register test done");
  endtask
  task automatic t_pins;
    for (int m = 0; m < 2; m++) begin
      // first clock-run on six, then lock on four and serial irq on three
      wr(8'h8C, m ? 32'h00021000 : 32'h01000000);
      for (int k = 0; k < 2; k++) begin
        @(posedge ref_clk);
        sv <= 33'h0;
        brd_oe <= 4'hF;
        brd_val <= k ? 4'hB : 4'h4;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("smp", m ? (k ? 32'h3C : 32'h25) : (k ? 32'h3E : 32'h39), smp);
      end
    end
    @(posedge ref_clk);
    brd_oe <= 4'h0;
    $display("input test done");
  endtask
  task automatic t_serial;
    @(posedge ref_clk);
    power_switch_data0 <= 1'h1;
    power_switch_data1 <= 1'h1;
    sv <= {2'h3, 31'h0};
    repeat (3) @(posedge ref_clk);
    #1;
    chk("sbm", 32'h1, serial_bus_mode);
    chk("t4", 32'h3, {term_oe[1], term_out[1]});
    @(posedge ref_clk);
    sv <= 33'h0;
    brd_oe <= 4'h2;
    brd_val <= 4'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("scl_in", 32'h0, smp[5]);
    @(posedge ref_clk);
    power_switch_data0 <= 1'h0;
    brd_oe <= 4'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("sbm", 32'h0, serial_bus_mode);
    $display("serial mode test done");
  endtask
  task automatic t_reset;
    @(posedge ref_clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("oe", 32'h0, term_oe);
    @(posedge ref_clk);
    sys_rst <= 1'h0;
    rd(8'h8C, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_route(input int t);
    logic [1:0] e;
    for (int c = 0; c < 16; c++) begin
      wr(8'h8C, 32'(c) << (12 + 4 * t));
      for (int k = 0; k < 3; k++) begin
        @(posedge ref_clk);
        sv <= k == 1 ? ~sv : {sv[29:0], sv[32:30]} ^ 33'h1A5C3;
        #1;
        e = ex(t, c[3:0]);
        chk("oe", e[1], term_oe[t]);
        if (e[1]) chk("out", e[0], term_out[t]);
      end
    end
    $display("route test %0d done", t);
  endtask

  initial begin
    // an x to one step at time zero gives the design a real reset edge
    sys_rst <= 1'h1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'h0;
    #1;
    chk("oe", 32'h0, term_oe);
    t_regs;
    t_pins;
    t_serial;
    t_route(0);
    t_route(1);
    t_route(2);
    t_route(3);
    t_reset;
    complete_run;
  end
endmodule
bind terminal_function_router router_properties #(.IRQ_W(IRQ_W)) i_router_properties (
  .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .eeprom_load, .irq_lines,
  .central_dma_grant, .scl_out, .term_out, .term_oe, .serial_bus_mode);
`default_nettype wire
